/* mep_pkg.sv */
// constants shared by the motion-end and home-preset block
// assumes a single 50 MHz clock and a 32-bit plain register port
package mep_pkg;
    localparam int unsigned MEP_CLK_HZ = 50_000_000;
    localparam int unsigned MEP_AW = 6;
    localparam int unsigned MEP_DW = 32;

    // register byte offsets
    localparam logic [5:0] MEP_OFS_CTRL = 6'h00;
    localparam logic [5:0] MEP_OFS_CMD = 6'h04;
    localparam logic [5:0] MEP_OFS_STATUS = 6'h08;
    localparam logic [5:0] MEP_OFS_POSCMD = 6'h0C;
    localparam logic [5:0] MEP_OFS_FBPOS = 6'h10;
    localparam logic [5:0] MEP_OFS_ENCCNT = 6'h14;
    localparam logic [5:0] MEP_OFS_POSERR = 6'h18;
    localparam logic [5:0] MEP_OFS_INT_STAT = 6'h1C;
    localparam logic [5:0] MEP_OFS_INT_EN = 6'h20;
    localparam logic [5:0] MEP_OFS_INT_CLR = 6'h24;

    // control register fields
    localparam int unsigned MEP_CTRL_AREA_LSB = 0;
    localparam int unsigned MEP_AREA_W = 16;
    localparam int unsigned MEP_CTRL_DRVEND_BIT = 16;
    localparam int unsigned MEP_CTRL_HDCS_BIT = 17;
    localparam logic [MEP_AREA_W-1:0] MEP_AREA_RST = 16'h0000;
    localparam logic MEP_DRVEND_RST = 1'b0;
    localparam logic MEP_HDCS_RST = 1'b0;

    // command register bits, write one to trigger
    localparam int unsigned MEP_CMD_HOME_BIT = 0;
    localparam int unsigned MEP_CMD_PLE_BIT = 1;
    localparam int unsigned MEP_CMD_SYNC_BIT = 2;

    // status register bits
    localparam int unsigned MEP_ST_END_BIT = 0;
    localparam int unsigned MEP_ST_BUSY_BIT = 1;
    localparam int unsigned MEP_ST_PRESET_BIT = 2;
    localparam int unsigned MEP_ST_ENREQ_BIT = 3;
    localparam int unsigned MEP_ST_DEVCLR_BIT = 4;
    localparam int unsigned MEP_ST_SRC_LSB = 5;

    // interrupt event bits
    localparam int unsigned MEP_NEV = 3;
    localparam int unsigned MEP_EV_END = 0;
    localparam int unsigned MEP_EV_HOME = 1;
    localparam int unsigned MEP_EV_REFUSED = 2;
    localparam logic [MEP_NEV-1:0] MEP_INT_RST = 3'h0;

    // pulse timing
    localparam int unsigned MEP_ENREQ_US = 1000;
    localparam int unsigned MEP_PRESET_US = 10;
    localparam int unsigned MEP_DEVCLR_US = 10;
    localparam int unsigned MEP_CYC_PER_US = MEP_CLK_HZ / 1_000_000;
    localparam int unsigned MEP_ENREQ_CYC = MEP_ENREQ_US * MEP_CYC_PER_US;
    localparam int unsigned MEP_PRESET_CYC = MEP_PRESET_US * MEP_CYC_PER_US;
    localparam int unsigned MEP_DEVCLR_CYC = MEP_DEVCLR_US * MEP_CYC_PER_US;

    typedef enum logic [1:0] {
        MEP_SRC_PULSE,
        MEP_SRC_AREA,
        MEP_SRC_DRIVER
    } mep_src_e;
endpackage

/* mep_pulse_timer.sv */
// one-shot pulse of a fixed number of clock cycles
// assumes start is a one-cycle pulse from logic on the same clock
`timescale 1ns/10ps
`default_nettype none
module mep_pulse_timer #(
    parameter int unsigned CYCLES = 500
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic start,
    output logic active_q
);
    localparam int unsigned CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYCLES);
    localparam logic [CW-1:0] ONE = CW'(1);

    logic [CW-1:0] cnt_q;

    // a start while running restarts the full width
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt_q <= '0;
            active_q <= 1'b0;
        end else if (start) begin
            cnt_q <= LOAD;
            active_q <= 1'b1;
        end else if (cnt_q > ONE) begin
            cnt_q <= cnt_q - ONE;
        end else begin
            cnt_q <= '0;
            active_q <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* mep_motion_end.sv */
// motion-end source selection, position bookkeeping and driver pulses
// assumes pulse generator, home seeker and driver position reader share CLK;
// drive end and encoder inputs come from pins and are synchronised here
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - end source from area width and select
// - area mode needs error within width
// - end output and internal end status
// - home set zeroes command, keeps error
// - home set pulses driver preset output
// - post-loss enable pulses request one millisecond
// - home seeking done pulses preset output
// - home done clears deviation when selected
// - sync loads driver position, keeps error
module mep_motion_end
    import mep_pkg::*;
#(
    parameter int unsigned ENREQ_CYCLES = mep_pkg::MEP_ENREQ_CYC
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [mep_pkg::MEP_AW-1:0] ADDR,
    input wire logic [mep_pkg::MEP_DW-1:0] WDATA,
    input wire logic WE,
    input wire logic RE,
    output logic [mep_pkg::MEP_DW-1:0] RDATA,
    input wire logic PULSE_BUSY,
    input wire logic CMD_STEP,
    input wire logic CMD_DIR,
    input wire logic ENC_STEP,
    input wire logic ENC_DIR,
    input wire logic DRV_END,
    input wire logic HOME_DONE,
    input wire logic [mep_pkg::MEP_DW-1:0] DRV_POS,
    output logic END_OUT,
    output logic MOTION_END,
    output logic PRESET_OUT,
    output logic ENABLE_REQ_OUT,
    output logic DEV_CLEAR_OUT,
    output logic IRQ
);
    import mep_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [1:0] drv_end_sync_q;
    logic [1:0] enc_step_sync_q;
    logic [1:0] enc_dir_sync_q;
    logic enc_step_prev_q;
    logic drv_end_s;
    logic enc_step_ev;

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            drv_end_sync_q <= 2'h0;
            enc_step_sync_q <= 2'h0;
            enc_dir_sync_q <= 2'h0;
            enc_step_prev_q <= 1'b0;
        end else begin
            drv_end_sync_q <= {drv_end_sync_q[0], DRV_END};
            enc_step_sync_q <= {enc_step_sync_q[0], ENC_STEP};
            enc_dir_sync_q <= {enc_dir_sync_q[0], ENC_DIR};
            enc_step_prev_q <= enc_step_sync_q[1];
        end
    end

    assign drv_end_s = drv_end_sync_q[1];
    assign enc_step_ev = enc_step_sync_q[1] & ~enc_step_prev_q;

    ////////////////////////////////////////////////////////////////////////////
    // register decode
    logic wr_ctrl;
    logic wr_cmd;
    logic wr_int_en;
    logic wr_int_clr;
    logic [MEP_AREA_W-1:0] area_q;
    logic drvend_sel_q;
    logic hdcs_q;
    logic [MEP_NEV-1:0] int_en_q;
    logic [MEP_NEV-1:0] int_stat_q;

    assign wr_ctrl = WE && (ADDR == MEP_OFS_CTRL);
    assign wr_cmd = WE && (ADDR == MEP_OFS_CMD);
    assign wr_int_en = WE && (ADDR == MEP_OFS_INT_EN);
    assign wr_int_clr = WE && (ADDR == MEP_OFS_INT_CLR);

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            area_q <= MEP_AREA_RST;
            drvend_sel_q <= MEP_DRVEND_RST;
            hdcs_q <= MEP_HDCS_RST;
        end else if (wr_ctrl) begin
            area_q <= WDATA[MEP_CTRL_AREA_LSB +: MEP_AREA_W];
            drvend_sel_q <= WDATA[MEP_CTRL_DRVEND_BIT];
            hdcs_q <= WDATA[MEP_CTRL_HDCS_BIT];
        end
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            int_en_q <= MEP_INT_RST;
        end else if (wr_int_en) begin
            int_en_q <= WDATA[MEP_NEV-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // commands; position loads are refused while pulses are being generated
    logic busy_q;
    logic home_cmd;
    logic ple_cmd;
    logic sync_cmd;
    logic home_ok;
    logic sync_ok;
    logic refused;

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= PULSE_BUSY;
        end
    end

    assign home_cmd = wr_cmd && WDATA[MEP_CMD_HOME_BIT];
    assign ple_cmd = wr_cmd && WDATA[MEP_CMD_PLE_BIT];
    assign sync_cmd = wr_cmd && WDATA[MEP_CMD_SYNC_BIT];
    assign home_ok = home_cmd && !busy_q;
    assign sync_ok = sync_cmd && !busy_q && !home_cmd;
    assign refused = (home_cmd || sync_cmd) && busy_q;

    ////////////////////////////////////////////////////////////////////////////
    // position command, encoder count and error; feedback equals count (1:1)
    logic [MEP_DW-1:0] pos_cmd_q;
    logic [MEP_DW-1:0] enc_cnt_q;
    logic [MEP_DW-1:0] pos_err;
    logic [MEP_DW-1:0] abs_pos_err;
    logic [MEP_DW-1:0] cmd_delta;
    logic [MEP_DW-1:0] enc_delta;

    assign pos_err = pos_cmd_q - enc_cnt_q;
    assign abs_pos_err = pos_err[MEP_DW-1] ? (~pos_err + 32'h00000001) : pos_err;
    assign cmd_delta = !CMD_STEP ? 32'h00000000 : (CMD_DIR ? 32'hFFFFFFFF : 32'h00000001);
    assign enc_delta = !enc_step_ev ? 32'h00000000 :
                       (enc_dir_sync_q[1] ? 32'hFFFFFFFF : 32'h00000001);

    // encoder steps of the load cycle are kept so no encoder count is lost; command steps are dropped
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            pos_cmd_q <= 32'h00000000;
            enc_cnt_q <= 32'h00000000;
        end else if (home_ok) begin
            pos_cmd_q <= 32'h00000000;
            enc_cnt_q <= enc_cnt_q - pos_cmd_q + enc_delta;
        end else if (sync_ok) begin
            pos_cmd_q <= DRV_POS;
            enc_cnt_q <= DRV_POS - pos_err + enc_delta;
        end else begin
            pos_cmd_q <= pos_cmd_q + cmd_delta;
            enc_cnt_q <= enc_cnt_q + enc_delta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // motion-end source and status
    mep_src_e src;
    logic end_q;
    logic end_cond;

    always_comb begin
        if (drvend_sel_q) begin
            src = MEP_SRC_DRIVER;
        end else if (area_q != MEP_AREA_RST) begin
            src = MEP_SRC_AREA;
        end else begin
            src = MEP_SRC_PULSE;
        end
    end

    always_comb begin
        unique case (src)
            MEP_SRC_PULSE: end_cond = 1'b1;
            MEP_SRC_AREA: end_cond = (abs_pos_err <= {16'h0000, area_q});
            MEP_SRC_DRIVER: end_cond = drv_end_s;
        endcase
    end

    // running pulse output always masks the end, whatever the source
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            end_q <= 1'b0;
        end else begin
            end_q <= !busy_q && !PULSE_BUSY && end_cond;
        end
    end

    assign END_OUT = end_q;
    assign MOTION_END = end_q;

    ////////////////////////////////////////////////////////////////////////////
    // driver pulses
    logic preset_start;
    logic devclr_start;
    logic preset_q;
    logic enreq_q;
    logic devclr_q;

    assign preset_start = home_ok || HOME_DONE;
    assign devclr_start = HOME_DONE && hdcs_q;

    mep_pulse_timer #(.CYCLES(MEP_PRESET_CYC)) u_preset (
        .clk(CLK),
        .nrst(NRST),
        .start(preset_start),
        .active_q(preset_q)
    );

    mep_pulse_timer #(.CYCLES(ENREQ_CYCLES)) u_enreq (
        .clk(CLK),
        .nrst(NRST),
        .start(ple_cmd),
        .active_q(enreq_q)
    );

    mep_pulse_timer #(.CYCLES(MEP_DEVCLR_CYC)) u_devclr (
        .clk(CLK),
        .nrst(NRST),
        .start(devclr_start),
        .active_q(devclr_q)
    );

    assign PRESET_OUT = preset_q;
    assign ENABLE_REQ_OUT = enreq_q;
    assign DEV_CLEAR_OUT = devclr_q;

    ////////////////////////////////////////////////////////////////////////////
    // interrupts: sticky events, set wins over clear
    logic end_prev_q;
    logic [MEP_NEV-1:0] ev;
    logic irq_q;

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            end_prev_q <= 1'b0;
        end else begin
            end_prev_q <= end_q;
        end
    end

    assign ev[MEP_EV_END] = end_q && !end_prev_q;
    assign ev[MEP_EV_HOME] = HOME_DONE;
    assign ev[MEP_EV_REFUSED] = refused;

    genvar gi;
    generate
        for (gi = 0; gi < MEP_NEV; gi++) begin : g_int
            always_ff @(posedge CLK) begin
                if (!NRST) begin
                    int_stat_q[gi] <= 1'b0;
                end else if (ev[gi]) begin
                    int_stat_q[gi] <= 1'b1;
                end else if (wr_int_clr && WDATA[gi]) begin
                    int_stat_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(int_stat_q & int_en_q);
        end
    end

    assign IRQ = irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // read path, data one cycle after the strobe
    logic [MEP_DW-1:0] rdata_q;
    logic [MEP_DW-1:0] status_w;

    always_comb begin
        status_w = 32'h00000000;
        status_w[MEP_ST_END_BIT] = end_q;
        status_w[MEP_ST_BUSY_BIT] = busy_q;
        status_w[MEP_ST_PRESET_BIT] = preset_q;
        status_w[MEP_ST_ENREQ_BIT] = enreq_q;
        status_w[MEP_ST_DEVCLR_BIT] = devclr_q;
        status_w[MEP_ST_SRC_LSB +: 2] = src;
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            rdata_q <= 32'h00000000;
        end else if (RE) begin
            unique case (ADDR)
                MEP_OFS_CTRL: rdata_q <= {14'h0000, hdcs_q, drvend_sel_q, area_q};
                MEP_OFS_STATUS: rdata_q <= status_w;
                MEP_OFS_POSCMD: rdata_q <= pos_cmd_q;
                MEP_OFS_FBPOS: rdata_q <= enc_cnt_q;
                MEP_OFS_ENCCNT: rdata_q <= enc_cnt_q;
                MEP_OFS_POSERR: rdata_q <= pos_err;
                MEP_OFS_INT_STAT: rdata_q <= {29'h00000000, int_stat_q};
                MEP_OFS_INT_EN: rdata_q <= {29'h00000000, int_en_q};
                default: rdata_q <= 32'h00000000;
            endcase
        end else begin
            rdata_q <= 32'h00000000;
        end
    end

    assign RDATA = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    end_busy_low_a: assert property (busy_q |=> !end_q)
        else $error("end seen during pulse output");
    end_pulse_mode_a: assert property (src == MEP_SRC_PULSE && !busy_q && !PULSE_BUSY
        && !wr_ctrl |=> end_q)
        else $error("end missing in pulse-end mode");
    end_area_a: assert property (end_q && $past(src) == MEP_SRC_AREA
        |-> $past(abs_pos_err) <= {16'h0000, $past(area_q)})
        else $error("end outside end area");
    end_driver_a: assert property (end_q && $past(src) == MEP_SRC_DRIVER
        |-> $past(drv_end_s))
        else $error("end without driver end");
    end_out_same_a: assert property (END_OUT == MOTION_END)
        else $error("end output and status differ");
    home_zero_a: assert property (home_ok && !CMD_STEP && !enc_step_ev
        |=> pos_cmd_q == 32'h00000000 && pos_err == $past(pos_err))
        else $error("home set did not zero command or keep error");
    home_preset_a: assert property (home_ok |=> PRESET_OUT [*8])
        else $error("preset missing after home set");
    enreq_width_a: assert property (ple_cmd |=> ENABLE_REQ_OUT [*8])
        else $error("enable request too short");
    logic [31:0] enreq_run_q;
    always_ff @(posedge CLK) begin
        if (!NRST || !enreq_q || ple_cmd) begin
            enreq_run_q <= 32'h00000000;
        end else begin
            enreq_run_q <= enreq_run_q + 32'h00000001;
        end
    end
    enreq_end_a: assert property (enreq_run_q <= ENREQ_CYCLES)
        else $error("enable request held too long");
    seek_preset_a: assert property (HOME_DONE |=> PRESET_OUT)
        else $error("preset missing after home seek");
    seek_devclr_a: assert property (HOME_DONE && hdcs_q |=> DEV_CLEAR_OUT)
        else $error("deviation clear missing");
    no_devclr_a: assert property (!DEV_CLEAR_OUT && !(HOME_DONE && hdcs_q)
        |=> !DEV_CLEAR_OUT)
        else $error("deviation clear without cause");
    sync_load_a: assert property (sync_ok && !CMD_STEP && !enc_step_ev
        |=> pos_cmd_q == $past(DRV_POS) && pos_err == $past(pos_err))
        else $error("sync did not load driver position");
    irq_level_a: assert property (##1 IRQ == $past(|(int_stat_q & int_en_q)))
        else $error("interrupt level wrong");

    end_after_move_c: cover property ($fell(busy_q) ##[1:4] end_q);
    area_end_c: cover property (src == MEP_SRC_AREA ##1 end_q);
    seek_done_c: cover property (HOME_DONE && hdcs_q ##1 DEV_CLEAR_OUT && PRESET_OUT);
    refused_c: cover property (refused ##1 int_stat_q[MEP_EV_REFUSED]);
endmodule
`default_nettype wire

/* mep_drv_model.sv */
// motor driver model: echoes command steps on the encoder pins, drives
// its end pin, keeps a driver position and measures the widths of pulses
// assumes the bench clock and reset; command steps come two cycles apart
`timescale 1ns/10ps
`default_nettype none
module mep_drv_model #(
    parameter logic [31:0] PRESET_OFS = 32'h00000064
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic cmd_step,
    input wire logic cmd_dir,
    input wire logic follow,
    input wire logic end_lvl,
    input wire logic preset,
    input wire logic enable_req,
    input wire logic dev_clear,
    output logic enc_step,
    output logic enc_dir,
    output logic drv_end,
    output logic [31:0] drv_pos,
    output logic [15:0] len [3]
);
    logic [2:0] pin;
    logic [2:0] pin_q;
    logic [15:0] cnt [3];
    assign pin = {dev_clear, enable_req, preset};

    ////////////////////////////////////////////////////////////////////////
    // encoder echo; follow low lets the position error build up on purpose
    always_ff @(posedge clk) begin
        enc_step <= nrst & follow & cmd_step;
        enc_dir <= cmd_dir;
        drv_end <= nrst & end_lvl;
    end

    ////////////////////////////////////////////////////////////////////////
    // a preset rise loads the driver's own nonzero offset, so the two ends
    // disagree until a sync
    always_ff @(posedge clk) begin
        if (!nrst) begin
            drv_pos <= 32'h00000000;
        end else if (pin[0] && !pin_q[0]) begin
            drv_pos <= PRESET_OFS;
        end else if (cmd_step) begin
            drv_pos <= cmd_dir ? drv_pos - 32'h1 : drv_pos + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // width of the last completed pulse: preset, enable request, dev clear
    always_ff @(posedge clk) begin
        pin_q <= nrst ? pin : 3'h0;
        for (int i = 0; i < 3; i++) begin
            if (!nrst) begin
                cnt[i] <= 16'h0;
                len[i] <= 16'h0;
            end else if (pin[i]) begin
                cnt[i] <= cnt[i] + 16'h1;
            end else if (pin_q[i]) begin
                len[i] <= cnt[i];
                cnt[i] <= 16'h0;
            end
        end
    end
endmodule
`default_nettype wire

/* mep_motion_end_tb_top.sv */
// self-checking bench of the motion-end and home-preset block
// assumes the driver model file; enable request shortened to 20 cycles
`timescale 1ns/10ps
`default_nettype none
module mep_motion_end_tb_top;
    import mep_pkg::*;
    localparam int unsigned ENREQ = 20;
    localparam logic [31:0] OFS = 32'h00000064;
    localparam logic [31:0] PW = 32'(MEP_PRESET_CYC);
    logic clk, nrst, we, re, pulse_busy, cmd_step, cmd_dir, enc_step, enc_dir;
    logic drv_end, home_done, end_out, motion_end, preset_out, enable_req_out;
    logic dev_clear_out, irq, follow, end_lvl;
    logic [5:0] addr;
    logic [31:0] wdata, rdata, drv_pos, v;
    logic [15:0] len [3];
    int failures, n_tests;

    mep_motion_end #(.ENREQ_CYCLES(ENREQ)) i_mep_motion_end (
        .CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WE(we), .RE(re),
        .RDATA(rdata), .PULSE_BUSY(pulse_busy), .CMD_STEP(cmd_step),
        .CMD_DIR(cmd_dir), .ENC_STEP(enc_step), .ENC_DIR(enc_dir),
        .DRV_END(drv_end), .HOME_DONE(home_done), .DRV_POS(drv_pos),
        .END_OUT(end_out), .MOTION_END(motion_end), .PRESET_OUT(preset_out),
        .ENABLE_REQ_OUT(enable_req_out), .DEV_CLEAR_OUT(dev_clear_out), .IRQ(irq));
    mep_drv_model #(.PRESET_OFS(OFS)) i_mep_drv_model (
        .clk(clk), .nrst(nrst), .cmd_step(cmd_step), .cmd_dir(cmd_dir),
        .follow(follow), .end_lvl(end_lvl), .preset(preset_out),
        .enable_req(enable_req_out), .dev_clear(dev_clear_out),
        .enc_step(enc_step), .enc_dir(enc_dir), .drv_end(drv_end),
        .drv_pos(drv_pos), .len(len));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [5:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic step(input logic dir, input int n);
        repeat (n) begin
            @(posedge clk);
            cmd_step <= 1'b1;
            cmd_dir <= dir;
            @(posedge clk);
            cmd_step <= 1'b0;
        end
    endtask
    task automatic busy(input logic b);
        @(posedge clk);
        pulse_busy <= b;
    endtask
    task automatic pulse_home_done;
        @(posedge clk);
        home_done <= 1'b1;
        @(posedge clk);
        home_done <= 1'b0;
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(MEP_OFS_CTRL, v);
        chk(v, 32'h0);
        rd(MEP_OFS_POSCMD, v);
        chk(v, 32'h0);
        rd(6'h3C, v);
        chk(v, 32'h0);
        chk(end_out, 1'b1);
        chk(motion_end, 1'b1);
    endtask
    task automatic t_pulse;
        busy(1'b1);
        cyc(1);
        chk(end_out, 1'b0);
        step(1'b0, 3);
        busy(1'b0);
        cyc(1);
        chk(end_out, 1'b0);
        cyc(1);
        chk(end_out, 1'b1);
        chk(motion_end, 1'b1);
        rd(MEP_OFS_STATUS, v);
        chk(v[6:5], 2'h0);
    endtask
    // encoder stalled: error 3 is outside width 2, error 2 sits on the edge
    task automatic t_area;
        follow <= 1'b0;
        wr(MEP_OFS_CTRL, 32'h2);
        rd(MEP_OFS_STATUS, v);
        chk(v[6:5], 2'h1);
        busy(1'b1);
        step(1'b0, 3);
        busy(1'b0);
        cyc(4);
        chk(end_out, 1'b0);
        rd(MEP_OFS_POSERR, v);
        chk(v, 32'h3);
        busy(1'b1);
        step(1'b1, 1);
        busy(1'b0);
        cyc(4);
        chk(end_out, 1'b1);
    endtask
    task automatic t_driver;
        wr(MEP_OFS_CTRL, 32'h10000);
        end_lvl <= 1'b0;
        cyc(8);
        chk(end_out, 1'b0);
        rd(MEP_OFS_STATUS, v);
        chk(v[6:5], 2'h2);
        end_lvl <= 1'b1;
        cyc(8);
        chk(end_out, 1'b1);
        wr(MEP_OFS_CTRL, 32'h0);
    endtask
    // home keeps the error of 2, sync takes the driver's offset position
    task automatic t_home_sync;
        wr(MEP_OFS_CMD, 32'h1);
        cyc(1);
        chk(preset_out, 1'b1);
        rd(MEP_OFS_POSCMD, v);
        chk(v, 32'h0);
        rd(MEP_OFS_POSERR, v);
        chk(v, 32'h2);
        cyc(MEP_PRESET_CYC + 4);
        chk(32'(len[0]), PW);
        wr(MEP_OFS_CMD, 32'h4);
        cyc(2);
        chk(preset_out, 1'b0);
        rd(MEP_OFS_POSCMD, v);
        chk(v, OFS);
        rd(MEP_OFS_POSERR, v);
        chk(v, 32'h2);
        rd(MEP_OFS_FBPOS, v);
        chk(v, OFS - 32'h2);
        rd(MEP_OFS_ENCCNT, v);
        chk(v, OFS - 32'h2);
    endtask
    task automatic t_recover;
        rd(MEP_OFS_POSCMD, v);
        wr(MEP_OFS_CMD, 32'h2);
        cyc(1);
        chk(enable_req_out, 1'b1);
        cyc(ENREQ + 3);
        chk(32'(len[1]), 32'(ENREQ));
        step(1'b0, 2);
        pulse_home_done();
        cyc(1);
        chk(preset_out, 1'b1);
        chk(dev_clear_out, 1'b0);
        cyc(MEP_PRESET_CYC + 4);
        chk(drv_pos, OFS);
        chk(32'(len[2]), 32'h0);
        wr(MEP_OFS_CTRL, 32'h20000);
        pulse_home_done();
        cyc(1);
        chk(dev_clear_out, 1'b1);
        cyc(MEP_DEVCLR_CYC + 4);
        chk(32'(len[2]), 32'(MEP_DEVCLR_CYC));
    endtask
    // a home command during pulsing is refused and raises the refused event
    task automatic t_irq;
        rd(MEP_OFS_INT_STAT, v);
        chk(v, 32'h3);
        wr(MEP_OFS_INT_CLR, 32'h7);
        cyc(2);
        chk(irq, 1'b0);
        wr(MEP_OFS_INT_EN, 32'h4);
        busy(1'b1);
        wr(MEP_OFS_CMD, 32'h1);
        busy(1'b0);
        rd(MEP_OFS_POSCMD, v);
        chk(v, OFS + 32'h2);
        chk(irq, 1'b1);
        rd(MEP_OFS_INT_STAT, v);
        chk(v & 32'h4, 32'h4);
        wr(MEP_OFS_INT_EN, 32'h0);
        cyc(2);
        chk(irq, 1'b0);
        wr(MEP_OFS_INT_EN, 32'h4);
        cyc(2);
        chk(irq, 1'b1);
        wr(MEP_OFS_INT_CLR, 32'h4);
        cyc(2);
        chk(irq, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        nrst = 1'b0;
        we = 1'b0;
        re = 1'b0;
        addr = 6'h00;
        wdata = 32'h0;
        pulse_busy = 1'b0;
        cmd_step = 1'b0;
        cmd_dir = 1'b0;
        home_done = 1'b0;
        follow = 1'b1;
        end_lvl = 1'b1;
        failures = 0;
        n_tests = 0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_pulse();
        t_area();
        t_driver();
        t_home_sync();
        t_recover();
        t_irq();
        final_report();
    end
    // the whole run is under two thousand cycles
    initial begin
        #(20 * 40000);
        failures++;
        final_report();
    end
endmodule
`default_nettype wire
